// ---- verilog/iofm_consts.svh ----
// Constants of the I/O function mapper: setting numbers, function codes, reset values.
// Assumes inclusion by every mapper file that decodes settings or codes.
//
// How it works
// - Code 12 motor running, duty; 112 inverse.
// - Code 13 target speed, duty; 113 inverse.
// - Codes 14/15 trimming, end reverse; 114/115 inverse.
// - Code 16 error stop indication; 116 inverse.
// - Code 17 roller lift solenoid; 117 inverse.
// - Roller lift is foot, reverse, switch OR.
// - Code 18 hemming output; 118 inverse.
// - Code 19 pedal first step; 119 inverse.
// - Same code on pins gives identical signals.
// - Undefined output codes are ignored, pin low.
// - Settings 50-57 pick inputs, default 0-7.
// - Settings 58-63 pick inputs, default 8-13.
// - Settings 64-66 pedal inputs, default 16-18.
// - Shared input function is OR of pins.
// - Settings 70/71 invert outputs with defined codes/all inputs.
`ifndef IOFM_CONSTS_SVH
`define IOFM_CONSTS_SVH

// ==========================================================================
// Setting numbers
`define IOFM_SET_OUT_BASE 7'h1C
`define IOFM_SET_IN_BASE  7'h32
`define IOFM_SET_OUT_INV  7'h46
`define IOFM_SET_IN_INV   7'h47

// ==========================================================================
// Output function codes
`define IOFM_INV_OFS      8'h64
`define IOFM_OUT_FN_CNT   8'h14
`define IOFM_DUTY_LIM     8'h0E
`define IOFM_FN_RUN       8'h0C
`define IOFM_FN_SPEED     8'h0D
`define IOFM_FN_TRIM      8'h0E
`define IOFM_FN_ENDBT     8'h0F
`define IOFM_FN_ESTOP     8'h10
`define IOFM_FN_ROLLER    8'h11
`define IOFM_FN_HEM       8'h12
`define IOFM_FN_PEDAL     8'h13
`define IOFM_FN_LOW       8'hC8
`define IOFM_FN_HIGH      8'hC9

// ==========================================================================
// Input function codes
`define IOFM_IN_FN_CNT    8'h15
`define IOFM_IN_FN_ROLLER 5'h0E
`define IOFM_IN_SKIP_AT   8'h0E
`define IOFM_IN_SKIP      8'h02

// ==========================================================================
// Reset values
`define IOFM_OUT_RST      8'hC8
`define IOFM_IN_RST(i)    (((i) < `IOFM_IN_SKIP_AT) ? (i) : (i) + `IOFM_IN_SKIP)

`endif

// ---- verilog/iofm_pkg.sv ----
// Types shared by the I/O function mapper.
// Assumes nothing of its surroundings.
package iofm_pkg;

    // ======================================================================
    // Types
    typedef logic [7:0] iofm_code_t;
    typedef logic [6:0] iofm_setnum_t;

endpackage

// ---- verilog/iofm_pwm.sv ----
// Free-running duty-cycle generator for chopped outputs.
// Assumes a duty level from the same clock domain.
`timescale 1ns/1ns
module iofm_pwm #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Duty level
    input  wire logic [W-1:0] duty,
    output logic              pwm_on
);

    logic [W-1:0] cnt_q;

    // ======================================================================
    // Counter and compare
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pwm_on <= 1'b0;
        end else begin
            pwm_on <= (cnt_q < duty);
        end
    end

endmodule

// ---- verilog/iofm_top.sv ----
// I/O function mapper: output pins pick internal signals by code, input pins pick functions.
// Assumes machine status inputs on clk; pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
`include "iofm_consts.svh"
module iofm_top #(
    parameter int N_OUT = 16,
    parameter int N_IN  = 17,
    parameter int PWM_W = 8
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Setting writes
    input  wire logic                 cfg_we,
    input  wire iofm_pkg::iofm_setnum_t cfg_num,
    input  wire iofm_pkg::iofm_code_t cfg_data,
    input  wire logic [PWM_W-1:0]     duty_level,
    // Machine status and actuators
    input  wire logic [11:0]          base_func,
    input  wire logic                 motor_running,
    input  wire logic                 target_speed,
    input  wire logic                 trimming_phase,
    input  wire logic                 end_backtack_phase,
    input  wire logic                 error_stop,
    input  wire logic                 foot_lift_sol,
    input  wire logic                 backtack_sol,
    input  wire logic                 hemming_out,
    input  wire logic                 pedal_first_step,
    // Pins
    input  wire logic [N_IN-1:0]      input_pin_n,
    output logic      [N_OUT-1:0]     output_pin_n,
    // Decoded input functions
    output logic [20:0]               in_func
);

    iofm_pkg::iofm_code_t out_code_q [N_OUT];
    iofm_pkg::iofm_code_t in_code_q  [N_IN];
    logic                 out_inv_q;
    logic                 in_inv_q;
    logic [N_IN-1:0]      sync1_q;
    logic [N_IN-1:0]      sync2_q;
    logic [N_OUT-1:0]     out_d;
    logic [N_OUT-1:0]     out_q;
    logic [20:0]          in_func_d;
    logic [20:0]          in_func_q;
    logic [19:0]          src;
    logic                 roller_sig;
    logic                 pwm_on;

    // ======================================================================
    // Setting store
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < N_OUT; i++) begin
                out_code_q[i] <= `IOFM_OUT_RST;
            end
            for (int i = 0; i < N_IN; i++) begin
                in_code_q[i] <= 8'(`IOFM_IN_RST(i));
            end
        end else if (cfg_we) begin
            if (cfg_num >= `IOFM_SET_OUT_BASE &&
                cfg_num < `IOFM_SET_OUT_BASE + 7'(N_OUT)) begin
                out_code_q[4'(cfg_num - `IOFM_SET_OUT_BASE)] <= cfg_data;
            end
            if (cfg_num >= `IOFM_SET_IN_BASE &&
                cfg_num < `IOFM_SET_IN_BASE + 7'(N_IN)) begin
                in_code_q[5'(cfg_num - `IOFM_SET_IN_BASE)] <= cfg_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_inv_q <= 1'b0;
            in_inv_q  <= 1'b0;
        end else if (cfg_we) begin
            if (cfg_num == `IOFM_SET_OUT_INV) begin
                out_inv_q <= cfg_data[0];
            end
            if (cfg_num == `IOFM_SET_IN_INV) begin
                in_inv_q <= cfg_data[0];
            end
        end
    end

    // ======================================================================
    // Input pin synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= input_pin_n;
            sync2_q <= sync1_q;
        end
    end

    // ======================================================================
    // Input function decode
    always_comb begin
        logic lvl;
        logic [7:0] c;
        lvl = 1'b0;
        c = 8'h00;
        in_func_d = '0;
        for (int p = 0; p < N_IN; p++) begin
            lvl = sync2_q[p] ^ in_inv_q;
            c = in_code_q[p];
            if (c < `IOFM_IN_FN_CNT) begin
                in_func_d[c[4:0]] = in_func_d[c[4:0]] | lvl;
            end else if (c >= `IOFM_INV_OFS && c < `IOFM_INV_OFS + `IOFM_IN_FN_CNT) begin
                in_func_d[5'(c - `IOFM_INV_OFS)] = in_func_d[5'(c - `IOFM_INV_OFS)] | ~lvl;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_func_q <= '0;
        end else begin
            in_func_q <= in_func_d;
        end
    end

    assign in_func = in_func_q;

    // ======================================================================
    // Output sources
    assign roller_sig = foot_lift_sol | backtack_sol | in_func_q[`IOFM_IN_FN_ROLLER];
    assign src = {pedal_first_step, hemming_out, roller_sig, error_stop,
                  end_backtack_phase, trimming_phase, target_speed, motor_running,
                  base_func};

    iofm_pwm #(
        .W (PWM_W)
    ) u_pwm (
        .clk    (clk),
        .srst   (srst),
        .duty   (duty_level),
        .pwm_on (pwm_on)
    );

    // Returns {valid, level} for one output code.
    function automatic logic [1:0] iofm_pick(input logic [7:0] code,
                                             input logic [19:0] s,
                                             input logic pwm);
        logic [7:0] base;
        logic       inv;
        logic       lvl;
        logic       ok;
        begin
            base = code;
            inv  = 1'b0;
            lvl  = 1'b0;
            ok   = 1'b0;
            if (code == `IOFM_FN_LOW) begin
                ok = 1'b1;
            end else if (code == `IOFM_FN_HIGH) begin
                ok  = 1'b1;
                lvl = 1'b1;
            end else begin
                if (code >= `IOFM_INV_OFS) begin
                    base = code - `IOFM_INV_OFS;
                    inv  = 1'b1;
                end
                if (base < `IOFM_OUT_FN_CNT) begin
                    ok  = 1'b1;
                    lvl = s[base[4:0]] ^ inv;
                    if (base < `IOFM_DUTY_LIM) begin
                        lvl = lvl & pwm;
                    end
                end
            end
            iofm_pick = {ok, lvl};
        end
    endfunction

    // ======================================================================
    // Output selection
    always_comb begin
        logic [1:0] r;
        r = 2'b00;
        out_d = '0;
        for (int i = 0; i < N_OUT; i++) begin
            r = iofm_pick(out_code_q[i], src, pwm_on);
            out_d[i] = r[1] ? (r[0] ^ out_inv_q) : 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign output_pin_n = out_q;

    // ======================================================================
    // Checks
    AST_RUN: assert property (@(posedge clk) disable iff (srst)
        out_code_q[0] == 8'h0C |=>
        output_pin_n[0] == (($past(motor_running) & $past(pwm_on)) ^ $past(out_inv_q)))
        else $error("Code 12 does not show motor running with duty.");

    AST_SPEED_INV: assert property (@(posedge clk) disable iff (srst)
        out_code_q[3] == 8'h71 |=>
        output_pin_n[3] == ((~$past(target_speed) & $past(pwm_on)) ^ $past(out_inv_q)))
        else $error("Code 113 does not show inverted target speed with duty.");

    AST_ENDBT: assert property (@(posedge clk) disable iff (srst)
        out_code_q[0] == 8'h0F |=>
        output_pin_n[0] == ($past(end_backtack_phase) ^ $past(out_inv_q)))
        else $error("Code 15 does not show end reverse phase.");

    AST_TRIM_NEXT: assert property (@(posedge clk) disable iff (srst)
        $changed(out_code_q[0]) && out_code_q[0] == 8'h0E |=>
        output_pin_n[0] == ($past(trimming_phase) ^ $past(out_inv_q)))
        else $error("New code 14 not applied on next cycle.");

    AST_ESTOP_INV: assert property (@(posedge clk) disable iff (srst)
        out_code_q[1] == 8'h74 |=>
        output_pin_n[1] == (~$past(error_stop) ^ $past(out_inv_q)))
        else $error("Code 116 does not show inverted error stop.");

    AST_ROLLER: assert property (@(posedge clk) disable iff (srst)
        out_code_q[0] == 8'h11 |=>
        output_pin_n[0] == (($past(foot_lift_sol) | $past(backtack_sol) |
                             $past(in_func_q[14])) ^ $past(out_inv_q)))
        else $error("Code 17 is not the roller lift OR.");

    AST_ROLLER_INV: assert property (@(posedge clk) disable iff (srst)
        out_code_q[1] == 8'h75 && !out_inv_q |=> output_pin_n[1] == ~$past(roller_sig))
        else $error("Code 117 is not inverted roller lift.");

    AST_HEM_INV: assert property (@(posedge clk) disable iff (srst)
        out_code_q[1] == 8'h76 |=>
        output_pin_n[1] == (~$past(hemming_out) ^ $past(out_inv_q)))
        else $error("Code 118 is not inverted hemming output.");

    AST_PEDAL: assert property (@(posedge clk) disable iff (srst)
        out_code_q[0] == 8'h13 |=>
        output_pin_n[0] == ($past(pedal_first_step) ^ $past(out_inv_q)))
        else $error("Code 19 does not show pedal first step.");

    AST_SAME_CODE: assert property (@(posedge clk) disable iff (srst)
        out_code_q[0] == out_code_q[1] |=> output_pin_n[0] == output_pin_n[1])
        else $error("Pins with equal codes differ.");

    AST_BAD_CODE: assert property (@(posedge clk) disable iff (srst)
        out_code_q[5] > 8'h13 && out_code_q[5] < 8'h64 |=> output_pin_n[5] == 1'b0)
        else $error("Undefined code drives a level.");

    AST_OUT_INV: assert property (@(posedge clk) disable iff (srst)
        out_code_q[0] == 8'hC9 |=> output_pin_n[0] == ~$past(out_inv_q))
        else $error("Global output inversion wrong.");

    AST_RST_FIRST: assert property (@(posedge clk)
        srst |=> in_code_q[0] == 8'h00 && in_code_q[7] == 8'h07)
        else $error("First eight input defaults wrong.");

    AST_RST_NEXT: assert property (@(posedge clk)
        srst |=> in_code_q[8] == 8'h08 && in_code_q[13] == 8'h0D)
        else $error("Next six input defaults wrong.");

    AST_RST_PEDAL: assert property (@(posedge clk)
        srst |=> in_code_q[14] == 8'h10 && in_code_q[15] == 8'h11 && in_code_q[16] == 8'h12)
        else $error("Pedal input defaults wrong.");

    AST_IN_OR: assert property (@(posedge clk) disable iff (srst)
        in_code_q[0] == 8'h00 && in_code_q[1] == 8'h00 && !in_inv_q &&
        (sync2_q[0] | sync2_q[1]) |=> in_func[0])
        else $error("Shared input function is not ORed.");

    AST_RUN_INV: assert property (@(posedge clk) disable iff (srst)
        out_code_q[1] == 8'h70 |=>
        output_pin_n[1] == ((~$past(motor_running) & $past(pwm_on)) ^ $past(out_inv_q)))
        else $error("Code 112 does not show inverted motor running with duty.");

    AST_SPEED: assert property (@(posedge clk) disable iff (srst)
        out_code_q[2] == 8'h0D |=>
        output_pin_n[2] == (($past(target_speed) & $past(pwm_on)) ^ $past(out_inv_q)))
        else $error("Code 13 does not show target speed with duty.");

    AST_TRIM_INV: assert property (@(posedge clk) disable iff (srst)
        out_code_q[1] == 8'h72 |=>
        output_pin_n[1] == (~$past(trimming_phase) ^ $past(out_inv_q)))
        else $error("Code 114 does not show inverted trimming phase.");

    AST_PWM_OFF: assert property (@(posedge clk) disable iff (srst)
        out_code_q[0] == 8'h0C && !pwm_on && !out_inv_q |=> !output_pin_n[0])
        else $error("Duty code drives its pin while the modulator is off.");

    AST_BAD_HIGH: assert property (@(posedge clk) disable iff (srst)
        (out_code_q[6] > 8'h77 && out_code_q[6] < 8'hC8) || out_code_q[6] > 8'hC9 |=>
        output_pin_n[6] == 1'b0)
        else $error("Undefined high code drives a level.");

    AST_IN_INV: assert property (@(posedge clk) disable iff (srst)
        in_code_q[2] == 8'h02 && in_inv_q && !sync2_q[2] |=> in_func[2])
        else $error("Global input inversion wrong.");

endmodule

// ---- bench/iofm_switch_model.sv ----
// Contact model for the switches and pedal contacts on the input pins.
// Assumes the bench says which contacts are closed; an open contact reads low.
`timescale 1ns/1ns
module iofm_switch_model #(
    parameter int N = 17
) (
    // Contact commands
    input  wire logic [N-1:0] closed,
    // Pin levels
    output logic      [N-1:0] pin
);
    // ======================================================================
    // Contacts
    // A closed contact pulls its pin high after a short settling delay.
    assign #2 pin = closed;
endmodule

// ---- bench/io_function_mapper_test.sv ----
// Self-checking bench for the I/O function mapper.
// Assumes the mapper package and constants are compiled first.
`timescale 1ns/1ns
module io_function_mapper_test;
    // ======================================================================
    // Signals
    logic                   clk        = 1'b0;
    logic                   srst       = 1'b1;
    logic                   cfg_we     = 1'b0;
    iofm_pkg::iofm_setnum_t cfg_num    = 7'h00;
    iofm_pkg::iofm_code_t   cfg_data   = 8'h00;
    logic [7:0]             duty_level = 8'h00;
    logic [11:0]            base_func  = 12'h000;
    logic [8:0]             src        = 9'h000;
    logic [16:0]            contact    = 17'h00000;
    logic [16:0]            input_pin_n;
    logic [15:0]            output_pin_n;
    logic [20:0]            in_func;
    int                     mismatches = 0;
    int                     tests_run  = 0;
    wire  [31:0]            outs = {16'h0000, output_pin_n};
    wire  [31:0]            ins  = {11'h000, in_func};

    always #4 clk = ~clk;

    iofm_switch_model #(.N(17)) sw_u (.closed(contact), .pin(input_pin_n));

    iofm_top dut_u (
        .clk                (clk),
        .srst               (srst),
        .cfg_we             (cfg_we),
        .cfg_num            (cfg_num),
        .cfg_data           (cfg_data),
        .duty_level         (duty_level),
        .base_func          (base_func),
        .motor_running      (src[0]),
        .target_speed       (src[1]),
        .trimming_phase     (src[2]),
        .end_backtack_phase (src[3]),
        .error_stop         (src[4]),
        .foot_lift_sol      (src[5]),
        .backtack_sol       (src[6]),
        .hemming_out        (src[7]),
        .pedal_first_step   (src[8]),
        .input_pin_n        (input_pin_n),
        .output_pin_n       (output_pin_n),
        .in_func            (in_func)
    );

    // ======================================================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_cfg(input logic [6:0] num, input logic [7:0] data);
        cfg_we   = 1'b1;
        cfg_num  = num;
        cfg_data = data;
        tick(1);
        cfg_we = 1'b0;
        tick(1);
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d, tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_defaults;
        chk(32'h00000000, outs);
        for (int i = 0; i < 17; i++) begin
            contact = 17'h00001 << i;
            tick(5);
            chk(32'h00000001 << ((i < 14) ? i : i + 2), ins);
        end
        contact = 17'h00000;
        tick(5);
    endtask

    task automatic t_latency;
        cfg_we   = 1'b1;
        cfg_num  = 7'h1C;
        cfg_data = 8'hC9;
        tick(1);
        cfg_we = 1'b0;
        chk(32'h00000000, outs);
        tick(1);
        chk(32'h00000001, outs);
        set_cfg(7'h1C, 8'hC8);
    endtask

    task automatic t_static_codes;
        int idx[6] = '{2, 3, 4, 5, 7, 8};
        for (int k = 0; k < 6; k++) begin
            set_cfg(7'h1C, 8'h0E + 8'(k));
            set_cfg(7'h1D, 8'h72 + 8'(k));
            src = 9'h000;
            tick(3);
            chk(32'h00000002, outs);
            src[idx[k]] = 1'b1;
            tick(3);
            chk(32'h00000001, outs);
        end
        src = 9'h000;
    endtask

    task automatic t_duty_codes;
        int hits;
        hits = 0;
        set_cfg(7'h1C, 8'h0C);
        set_cfg(7'h1D, 8'h70);
        set_cfg(7'h1E, 8'h0D);
        set_cfg(7'h1F, 8'h71);
        set_cfg(7'h20, 8'h07);
        base_func = 12'h080;
        src[0] = 1'b1;
        duty_level = 8'h00;
        tick(4);
        chk(32'h00000000, outs);
        duty_level = 8'hFF;
        tick(4);
        for (int c = 0; c < 4; c++) begin
            if (outs === 32'h00000019) hits++;
            tick(1);
        end
        chk(32'h00000003, 32'(hits > 2) + 32'h00000002);
        src = 9'h000;
        base_func = 12'h000;
        for (int p = 0; p < 5; p++) set_cfg(7'h1C + 7'(p), 8'hC8);
    endtask

    task automatic t_roller;
        set_cfg(7'h1C, 8'h11);
        set_cfg(7'h32, 8'h0E);
        contact = 17'h00001;
        tick(6);
        chk(32'h00004000, ins);
        chk(32'h00000001, outs);
        contact = 17'h00000;
        src[6] = 1'b1;
        tick(6);
        chk(32'h00000001, outs);
        src[6] = 1'b0;
        tick(3);
        chk(32'h00000000, outs);
        set_cfg(7'h32, 8'h00);
    endtask

    task automatic t_shared;
        set_cfg(7'h1C, 8'h13);
        set_cfg(7'h1F, 8'h13);
        set_cfg(7'h2B, 8'h13);
        set_cfg(7'h21, 8'h32);
        set_cfg(7'h22, 8'h78);
        src[8] = 1'b1;
        tick(3);
        chk(32'h00008009, outs);
        src[8] = 1'b0;
        set_cfg(7'h1C, 8'hC8);
        set_cfg(7'h1F, 8'hC8);
        set_cfg(7'h2B, 8'hC8);
        set_cfg(7'h46, 8'h01);
        tick(3);
        chk(32'h0000FF9F, outs);
        set_cfg(7'h46, 8'h00);
        set_cfg(7'h47, 8'h01);
        tick(6);
        chk(32'h00073FFF, ins);
        set_cfg(7'h47, 8'h00);
        tick(6);
    endtask

    task automatic t_input_or;
        set_cfg(7'h33, 8'h00);
        contact = 17'h00002;
        tick(6);
        chk(32'h00000001, ins);
        contact = 17'h00001;
        tick(6);
        chk(32'h00000001, ins);
        contact = 17'h00000;
        set_cfg(7'h33, 8'h71);
        tick(6);
        chk(32'h00002000, ins);
        set_cfg(7'h33, 8'h01);
        tick(6);
        chk(32'h00000000, ins);
    endtask

    task automatic t_reset;
        set_cfg(7'h1C, 8'hC9);
        set_cfg(7'h46, 8'h01);
        set_cfg(7'h32, 8'h05);
        contact = 17'h00001;
        tick(5);
        chk(32'h00000020, ins);
        srst = 1'b1;
        tick(2);
        chk(32'h00000000, outs);
        chk(32'h00000000, ins);
        srst = 1'b0;
        tick(5);
        chk(32'h00000000, outs);
        chk(32'h00000001, ins);
        contact = 17'h00000;
        tick(5);
    endtask

    // ======================================================================
    // Main sequence and watchdog
    initial begin
        tick(10);
        srst = 1'b0;
        tick(1);
        t_defaults();
        t_latency();
        t_static_codes();
        t_duty_codes();
        t_roller();
        t_shared();
        t_input_or();
        t_reset();
        complete_run();
    end

    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule
